// [hnb_regs.svh]
// constants of the nibble-bus write cycle
`ifndef HNB_REGS_SVH
`define HNB_REGS_SVH
`define HNB_START_WRITE 4'he
`define HNB_SIZE_BYTE 4'h0
`define HNB_TAR_NIBBLE 4'hf
`define HNB_SYNC_OK 4'h0
`define HNB_ADDR_NIBBLES 4'h7
`define HNB_IDLE_NIBBLE 4'hf
`endif

// [hnb_pkg.sv]
// types shared by both ends of the nibble-bus write cycle
package hnb_pkg;
   typedef logic [3:0] hnb_nibble_t;
   typedef logic [27:0] hnb_addr_t;
   typedef logic [7:0] hnb_byte_t;
   typedef enum logic [3:0]
   {
      HNB_IDLE = 4'h0,
      HNB_SEL = 4'h1,
      HNB_ADDR = 4'h2,
      HNB_SIZE = 4'h3,
      HNB_DLO = 4'h4,
      HNB_DHI = 4'h5,
      HNB_TAR1 = 4'h6,
      HNB_TAR2 = 4'h7,
      HNB_SYNC = 4'h8,
      HNB_TAR3 = 4'h9,
      HNB_TAR4 = 4'ha
   } hnb_state_t;
endpackage : hnb_pkg

// [hnb_if.sv]
// interface joining host and target on the nibble bus
`timescale 1ns/1ps
`default_nettype none
`include "hnb_regs.svh"
interface hnb_if;
   logic [3:0] host_nibble_o;
   logic host_nibble_oe;
   logic [3:0] tgt_nibble_o;
   logic tgt_nibble_oe;
   logic frame_strobe_n;
   logic [3:0] host_nibble_lines;
   // wired bus: an undriven line floats to the pulled-up level
   assign host_nibble_lines = host_nibble_oe ? host_nibble_o :
      (tgt_nibble_oe ? tgt_nibble_o : `HNB_IDLE_NIBBLE);
   modport host (output host_nibble_o, output host_nibble_oe, output frame_strobe_n,
      input host_nibble_lines);
   modport target (output tgt_nibble_o, output tgt_nibble_oe, input frame_strobe_n,
      input host_nibble_lines);
endinterface : hnb_if
`default_nettype wire

// [hnb_target.sv]
// target end of the nibble-bus write cycle
//
// How it works
// - start nibble 1110b with frame low opens write
// - second nibble compared against identity straps
// - seven address nibbles, most significant first
// - size nibble must be 0000b, one byte
// - data byte arrives low nibble first
// - host drives 1111b in clock 13
// - clock 14 host floats, target takes bus
// - target drives 0000b sync in clock 15
// - target drives 1111b in clock 16
// - target floats in clock 17
// - frame high between cycles means standby: target floats, host drives 1111b
// - either reset low aborts and floats
`timescale 1ns/1ps
`default_nettype none
`include "hnb_regs.svh"
module hnb_target
(
   // clock and resets
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic interface_reset_n_i,
   input wire logic cpu_reset_n_i,
   // straps
   input wire logic [3:0] identity_strap_inputs_i,
   // bus
   hnb_if.target bus,
   // command interpreter side
   output logic wr_valid_o,
   output hnb_pkg::hnb_addr_t wr_addr_o,
   output hnb_pkg::hnb_byte_t wr_data_o
);
   import hnb_pkg::*;

   // ==========================================
   // input synchronisers
   // the reset pins are asynchronous levels: the target stays idle for the two
   // sync clocks after reset_i, the price of never acting on a half-seen edge
   logic [1:0] rst_sync_ff;
   logic rst_s;
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], interface_reset_n_i & cpu_reset_n_i};
   end
   assign rst_s = ~rst_sync_ff[1];

   // straps are pins as well; a strap change needs two clocks before the
   // select compare sees it
   logic [3:0] strap_sync1_ff;
   logic [3:0] strap_sync2_ff;
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         strap_sync1_ff <= 4'h0;
         strap_sync2_ff <= 4'h0;
      end
      else
      begin
         strap_sync1_ff <= identity_strap_inputs_i;
         strap_sync2_ff <= strap_sync1_ff;
      end
   end

   // ==========================================
   // cycle state
   hnb_state_t state_ff, nxt_state;
   logic [2:0] cnt_ff, nxt_cnt;
   logic sel_ff, nxt_sel;
   hnb_addr_t addr_ff, nxt_addr;
   hnb_byte_t data_ff, nxt_data;
   logic [3:0] out_ff, nxt_out;
   logic oe_ff, nxt_oe;
   logic valid_ff, nxt_valid;
   hnb_addr_t wa_ff, nxt_wa;
   hnb_byte_t wd_ff, nxt_wd;
   hnb_nibble_t nib;
   logic frame_n;

   // bus fields are sampled directly: the host drives them from this clock
   assign nib = bus.host_nibble_lines;
   assign frame_n = bus.frame_strobe_n;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_sel = sel_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_out = `HNB_IDLE_NIBBLE;
      nxt_oe = 1'b0;
      nxt_valid = 1'b0;
      nxt_wa = wa_ff;
      nxt_wd = wd_ff;
      case (state_ff)
         HNB_IDLE: // standby: nothing driven until a start is seen
         begin
            if (!frame_n && nib == `HNB_START_WRITE)
               nxt_state = HNB_SEL;
         end
         HNB_SEL:
         begin
            nxt_sel = (nib == strap_sync2_ff);
            nxt_cnt = 3'h0;
            nxt_state = HNB_ADDR;
         end
         HNB_ADDR:
         begin
            nxt_addr = {addr_ff[23:0], nib};
            nxt_cnt = cnt_ff + 3'h1;
            if ({1'b0, cnt_ff} == `HNB_ADDR_NIBBLES - 4'h1)
               nxt_state = HNB_SIZE;
         end
         HNB_SIZE:
         begin
            // a multi-byte size is not ours to answer; drop selection
            if (nib != `HNB_SIZE_BYTE)
               nxt_sel = 1'b0;
            nxt_state = HNB_DLO;
         end
         HNB_DLO:
         begin
            nxt_data = {data_ff[7:4], nib};
            nxt_state = HNB_DHI;
         end
         HNB_DHI:
         begin
            nxt_data = {nib, data_ff[3:0]};
            nxt_state = HNB_TAR1;
         end
         HNB_TAR1:
         begin
            // host drives 1111b now; we start driving from clock 14
            nxt_state = HNB_TAR2;
            nxt_oe = sel_ff;
            nxt_out = `HNB_TAR_NIBBLE;
         end
         HNB_TAR2:
         begin
            nxt_state = HNB_SYNC;
            nxt_oe = sel_ff;
            nxt_out = `HNB_SYNC_OK;
         end
         HNB_SYNC:
         begin
            nxt_state = HNB_TAR3;
            nxt_oe = sel_ff;
            nxt_out = `HNB_TAR_NIBBLE;
            nxt_valid = sel_ff;
            nxt_wa = addr_ff;
            nxt_wd = data_ff;
         end
         HNB_TAR3:
         begin
            nxt_state = HNB_IDLE;
         end
         default:
         begin
            nxt_state = HNB_IDLE;
         end
      endcase
      // frame high during the host phases aborts the cycle
      if (frame_n && state_ff != HNB_IDLE && state_ff < HNB_TAR1)
         nxt_state = HNB_IDLE;
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_ff <= HNB_IDLE;
         cnt_ff <= 3'h0;
         sel_ff <= 1'b0;
         addr_ff <= 28'h0;
         data_ff <= 8'h0;
         out_ff <= `HNB_IDLE_NIBBLE;
         oe_ff <= 1'b0;
         valid_ff <= 1'b0;
         wa_ff <= 28'h0;
         wd_ff <= 8'h0;
      end
      else if (rst_s)
      begin
         state_ff <= HNB_IDLE;
         sel_ff <= 1'b0;
         oe_ff <= 1'b0;
         valid_ff <= 1'b0;
         out_ff <= `HNB_IDLE_NIBBLE;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         sel_ff <= nxt_sel;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         valid_ff <= nxt_valid;
         wa_ff <= nxt_wa;
         wd_ff <= nxt_wd;
      end
   end

   assign bus.tgt_nibble_o = out_ff;
   assign bus.tgt_nibble_oe = oe_ff;
   assign wr_valid_o = valid_ff;
   assign wr_addr_o = wa_ff;
   assign wr_data_o = wd_ff;
endmodule : hnb_target
`default_nettype wire

// [hnb_host.sv]
// host end of the nibble-bus write cycle
`timescale 1ns/1ps
`default_nettype none
`include "hnb_regs.svh"
module hnb_host
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // request side
   input wire logic req_i,
   input wire logic [3:0] req_id_i,
   input wire hnb_pkg::hnb_addr_t req_addr_i,
   input wire hnb_pkg::hnb_byte_t req_data_i,
   output logic busy_o,
   output logic done_o,
   output logic ack_o,
   // bus
   hnb_if.host bus
);
   import hnb_pkg::*;

   // ==========================================
   // cycle sequencer
   hnb_state_t state_ff, nxt_state;
   logic [2:0] cnt_ff, nxt_cnt;
   hnb_addr_t addr_ff, nxt_addr;
   hnb_byte_t data_ff, nxt_data;
   logic [3:0] id_ff, nxt_id;
   logic [3:0] out_ff, nxt_out;
   logic oe_ff, nxt_oe;
   logic frame_n_ff, nxt_frame_n;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;
   logic ack_ff, nxt_ack;

   // registered drive: out_ff shows in the clock after the state that chose it
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_id = id_ff;
      nxt_out = `HNB_IDLE_NIBBLE;
      nxt_oe = 1'b1;
      nxt_frame_n = 1'b1;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_ack = ack_ff;
      case (state_ff)
         HNB_IDLE:
         begin
            if (req_i)
            begin
               nxt_addr = req_addr_i;
               nxt_data = req_data_i;
               nxt_id = req_id_i;
               nxt_busy = 1'b1;
               nxt_ack = 1'b0;
               nxt_frame_n = 1'b0;
               nxt_out = `HNB_START_WRITE;
               nxt_state = HNB_SEL;
            end
         end
         HNB_SEL:
         begin
            // frame stays low through the host phases: a high frame there
            // aborts the target
            nxt_frame_n = 1'b0;
            nxt_out = id_ff;
            nxt_cnt = 3'h0;
            nxt_state = HNB_ADDR;
         end
         HNB_ADDR:
         begin
            nxt_frame_n = 1'b0;
            nxt_out = addr_ff[27:24];
            nxt_addr = {addr_ff[23:0], 4'h0};
            nxt_cnt = cnt_ff + 3'h1;
            if ({1'b0, cnt_ff} == `HNB_ADDR_NIBBLES - 4'h1)
               nxt_state = HNB_SIZE;
         end
         HNB_SIZE:
         begin
            nxt_frame_n = 1'b0;
            nxt_out = `HNB_SIZE_BYTE;
            nxt_state = HNB_DLO;
         end
         HNB_DLO:
         begin
            nxt_frame_n = 1'b0;
            nxt_out = data_ff[3:0];
            nxt_state = HNB_DHI;
         end
         HNB_DHI:
         begin
            nxt_frame_n = 1'b0;
            nxt_out = data_ff[7:4];
            nxt_state = HNB_TAR1;
         end
         HNB_TAR1:
         begin
            nxt_out = `HNB_TAR_NIBBLE;
            nxt_state = HNB_TAR2;
         end
         HNB_TAR2:
         begin
            nxt_oe = 1'b0;
            nxt_state = HNB_SYNC;
         end
         HNB_SYNC:
         begin
            nxt_oe = 1'b0;
            nxt_state = HNB_TAR3;
         end
         HNB_TAR3:
         begin
            // bus shows clock 15 now: the sync nibble
            nxt_oe = 1'b0;
            nxt_ack = (bus.host_nibble_lines == `HNB_SYNC_OK);
            nxt_state = HNB_TAR4;
         end
         HNB_TAR4:
         begin
            nxt_oe = 1'b0;
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_state = HNB_IDLE;
         end
         default:
         begin
            nxt_state = HNB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_ff <= HNB_IDLE;
         cnt_ff <= 3'h0;
         addr_ff <= 28'h0;
         data_ff <= 8'h0;
         id_ff <= 4'h0;
         out_ff <= `HNB_IDLE_NIBBLE;
         oe_ff <= 1'b0;
         frame_n_ff <= 1'b1;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         ack_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         id_ff <= nxt_id;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         frame_n_ff <= nxt_frame_n;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         ack_ff <= nxt_ack;
      end
   end

   assign bus.host_nibble_o = out_ff;
   assign bus.host_nibble_oe = oe_ff;
   assign bus.frame_strobe_n = frame_n_ff;
   assign busy_o = busy_ff;
   assign done_o = done_ff;
   assign ack_o = ack_ff;
endmodule : hnb_host
`default_nettype wire

// [hnb_properties.sv]
// wire-level checker for the nibble-bus write cycle
`timescale 1ns/1ps
`default_nettype none
module hnb_properties
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // bus
   input wire logic host_nibble_oe,
   input wire logic [3:0] tgt_nibble_o,
   input wire logic tgt_nibble_oe,
   input wire logic frame_strobe_n,
   input wire logic [3:0] host_nibble_lines
);
   // ==========================================
   // cycle timing, counted from the start edge or from the target's rise of tgt_nibble_oe
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);
   start_code_a: assert property ($fell(frame_strobe_n) |->
      host_nibble_lines == 4'he)
      else $error("start nibble wrong");
   frame_span_a: assert property ($fell(frame_strobe_n) |->
      ##11 !frame_strobe_n ##1 frame_strobe_n)
      else $error("frame not held over host phases");
   size_zero_a: assert property ($fell(frame_strobe_n) |->
      ##9 host_nibble_lines == 4'h0)
      else $error("size nibble wrong");
   host_tar_a: assert property ($fell(frame_strobe_n) |->
      ##12 host_nibble_oe && host_nibble_lines == 4'hf)
      else $error("host turnaround wrong");
   host_release_a: assert property ($fell(frame_strobe_n) |->
      ##13 (!host_nibble_oe)[*4])
      else $error("host kept the bus");
   tgt_claim_a: assert property ($rose(tgt_nibble_oe) |->
      tgt_nibble_o == 4'hf && $past(frame_strobe_n, 13) == 1'b0)
      else $error("target claimed bus off time");
   sync_tar_a: assert property ($rose(tgt_nibble_oe) |=>
      tgt_nibble_oe && tgt_nibble_o == 4'h0 ##1 tgt_nibble_oe && tgt_nibble_o == 4'hf)
      else $error("sync or closing turnaround wrong");
   tgt_float_a: assert property ($rose(tgt_nibble_oe) |->
      ##3 !tgt_nibble_oe)
      else $error("target did not float");
   bus_owner_a: assert property (tgt_nibble_oe |-> !host_nibble_oe)
      else $error("both ends drive");
endmodule : hnb_properties
`default_nettype wire

// [tb_top.sv]
// self-checking bench joining host and target over the nibble bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hnb_pkg::*;
   logic clock_i, reset_i, irst_n, crst_n, req, busy, done, ack, wr_valid;
   logic [3:0] strap, req_id;
   hnb_addr_t req_addr, wr_addr;
   hnb_byte_t req_data, wr_data;
   int err_total, n_checks, n_wr;
   hnb_if bus_if();
   hnb_host i_hnb_host (.clock_i(clock_i), .reset_i(reset_i), .req_i(req), .req_id_i(req_id),
      .req_addr_i(req_addr), .req_data_i(req_data), .busy_o(busy), .done_o(done),
      .ack_o(ack), .bus(bus_if));
   hnb_target i_hnb_target (.clock_i(clock_i), .reset_i(reset_i), .interface_reset_n_i(irst_n),
      .cpu_reset_n_i(crst_n), .identity_strap_inputs_i(strap), .bus(bus_if),
      .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
   hnb_properties i_hnb_properties (.clock_i(clock_i), .reset_i(reset_i),
      .host_nibble_oe(bus_if.host_nibble_oe), .tgt_nibble_o(bus_if.tgt_nibble_o),
      .tgt_nibble_oe(bus_if.tgt_nibble_oe), .frame_strobe_n(bus_if.frame_strobe_n),
      .host_nibble_lines(bus_if.host_nibble_lines));
   // ==========================================
   // clock, watchdog and checking helpers
   initial
   begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   initial
   begin
      #(40 * 2000);
      err_total++;
      test_done();
   end
   always @(posedge clock_i) if (wr_valid === 1'b1) n_wr++;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   // one write; entered just after an edge, leaves just after done
   task automatic wr_cycle(input logic [3:0] id, input hnb_addr_t a, input hnb_byte_t d);
      logic sel;
      logic [3:0] exp [1:17];
      int base;
      sel = (id == strap);
      base = n_wr;
      exp[1] = 4'he;
      exp[2] = id;
      for (int j = 0; j < 7; j++) exp[3 + j] = a[27 - 4 * j -: 4];
      exp[10] = 4'h0;
      exp[11] = d[3:0];
      exp[12] = d[7:4];
      for (int k = 13; k <= 17; k++) exp[k] = 4'hf;
      if (sel) exp[15] = 4'h0;
      req = 1'b1;
      req_id = id;
      req_addr = a;
      req_data = d;
      @(posedge clock_i);
      for (int k = 1; k <= 17; k++)
      begin
         #1;
         req = 1'b0;
         check(bus_if.host_nibble_lines, exp[k]);
         check(bus_if.tgt_nibble_oe, sel && k >= 14 && k <= 16);
         if (k == 1) check(bus_if.frame_strobe_n, 0);
         if (k == 1) check(busy, 1);
         if (k == 17) check(done, 1);
         if (k == 17) check(busy, 0);
         @(posedge clock_i);
      end
      #1;
      check(done, 0);
      check(ack, sel);
      check(n_wr - base, sel);
      if (sel) check(wr_addr, a);
      if (sel) check(wr_data, d);
   endtask : wr_cycle
   // pin reset in mid-cycle: target must drop the write and never drive
   task automatic abort_cycle(input logic use_if);
      int base;
      int n;
      base = n_wr;
      n = 0;
      req = 1'b1;
      req_id = strap;
      req_addr = 28'h1234567;
      req_data = 8'h3c;
      repeat (3) @(posedge clock_i);
      #1;
      req = 1'b0;
      irst_n = !use_if;
      crst_n = use_if;
      while (done !== 1'b1 && n < 30)
      begin
         @(posedge clock_i);
         #1;
         n++;
         check(bus_if.tgt_nibble_oe, 0);
      end
      check(ack, 0);
      check(n_wr - base, 0);
      irst_n = 1'b1;
      crst_n = 1'b1;
      repeat (4) @(posedge clock_i);
      #1;
   endtask : abort_cycle
   // ==========================================
   // test sequence
   initial
   begin
      reset_i = 1'b1;
      irst_n = 1'b1;
      crst_n = 1'b1;
      strap = 4'h5;
      req = 1'b0;
      req_id = 4'h0;
      req_addr = 28'h0;
      req_data = 8'h0;
      repeat (8) @(posedge clock_i);
      #1;
      check(bus_if.tgt_nibble_oe, 0);
      check(bus_if.host_nibble_lines, 4'hf);
      reset_i = 1'b0;
      @(posedge clock_i);
      #1;
      wr_cycle(4'h5, 28'hfedcba9, 8'h5a);
      wr_cycle(4'h5, 28'h0000001, 8'ha5);
      wr_cycle(4'h4, 28'h7654321, 8'h81);
      strap = 4'ha;
      wr_cycle(4'ha, 28'hfffffff, 8'hff);
      abort_cycle(1'b1);
      abort_cycle(1'b0);
      wr_cycle(4'ha, 28'h0000000, 8'h00);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
